// [bench/sleep_state_error_masking_assertions.sv]
// Port-level assertions of the sleep-state error masking block
`timescale 1ns/1ps
`default_nettype none
module sleep_mask_checker #(
    parameter INPUTS = 8,
    parameter FANS = 4
) (
    // Clock, reset and read port
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // Raw events
    input wire logic [INPUTS-1:0] INPUT_ERROR_EVENT,
    input wire logic [FANS-1:0] FAN_ERROR_EVENT,
    input wire logic [2:0] ANALOG_HIGH_ERROR_EVENT,
    input wire logic [1:0] ZONE_TEMP_ERROR_EVENT,
    input wire logic [1:0] REGULATOR_HOT_EVENT,
    input wire logic [1:0] TERMINATION_EVENT,
    // Masked events
    input wire logic [INPUTS-1:0] INPUT_ERROR_STATUS,
    input wire logic [FANS-1:0] FAN_ERROR,
    input wire logic [2:0] ANALOG_HIGH_ERROR,
    input wire logic [1:0] ZONE_TEMP_ERROR,
    input wire logic [1:0] REGULATOR_HOT_ERROR,
    input wire logic [1:0] TERMINATION_ERROR
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SRST);
    a_input_gate_raw: assert property (!(INPUT_ERROR_STATUS & ~$past(INPUT_ERROR_EVENT)))
        else $error("input error without event");
    a_fan_gate_raw: assert property (!(FAN_ERROR & ~$past(FAN_ERROR_EVENT)))
        else $error("fan error without event");
    a_analog_needs_event: assert property (|ANALOG_HIGH_ERROR
        |-> |$past(ANALOG_HIGH_ERROR_EVENT))
        else $error("analog error without event");
    a_zone_gate_raw: assert property (!(ZONE_TEMP_ERROR & ~$past(ZONE_TEMP_ERROR_EVENT)))
        else $error("zone error without event");
    a_regulator_rise: assert property ($rose(REGULATOR_HOT_ERROR[0])
        |-> $past(REGULATOR_HOT_EVENT[0]))
        else $error("regulator error without event");
    a_termination_gate: assert property (
        !(TERMINATION_ERROR & ~$past(TERMINATION_EVENT)))
        else $error("termination error without event");
    a_reset_off_state: assert property ($fell(SRST) |-> ##1 (ANALOG_HIGH_ERROR == 3'h0))
        else $error("analog error passed after reset");
    a_rdata_idle_zero: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside read slot");
    c_fan: cover property (FAN_ERROR != 4'h0);
    c_read: cover property (REG_RD ##1 REG_RDATA != 8'h00);
    c_regulator: cover property (REGULATOR_HOT_ERROR != 2'h0);
endmodule
bind sleep_state_error_masking sleep_mask_checker #(.INPUTS(INPUTS), .FANS(FANS)) u_chk (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .INPUT_ERROR_EVENT(INPUT_ERROR_EVENT), .FAN_ERROR_EVENT(FAN_ERROR_EVENT),
    .ANALOG_HIGH_ERROR_EVENT(ANALOG_HIGH_ERROR_EVENT),
    .ZONE_TEMP_ERROR_EVENT(ZONE_TEMP_ERROR_EVENT),
    .REGULATOR_HOT_EVENT(REGULATOR_HOT_EVENT), .TERMINATION_EVENT(TERMINATION_EVENT),
    .INPUT_ERROR_STATUS(INPUT_ERROR_STATUS), .FAN_ERROR(FAN_ERROR),
    .ANALOG_HIGH_ERROR(ANALOG_HIGH_ERROR), .ZONE_TEMP_ERROR(ZONE_TEMP_ERROR),
    .REGULATOR_HOT_ERROR(REGULATOR_HOT_ERROR), .TERMINATION_ERROR(TERMINATION_ERROR)
);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench of the sleep-state error masking block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic ev_vld = 1'b0, rd_due = 1'b0, ev_due = 1'b0, glob = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pins = 8'h00, st = 8'h00, imk = 8'h00, a;
    logic [32:0] ev = '0;
    wire [32:0] o;
    wire [7:0] rdata, in_state;
    wire irq;
    logic [7:0] sh [logic [7:0]];
    logic [7:0] q_rd [$];
    logic [32:0] q_ev [$];
    int n_errors = 0, compares = 0, r;
    sleep_state_error_masking dut (
        .CORE_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .INPUT_ERROR_EVENT(ev[32:25]),
        .INPUT_ERROR_EXT_EVENT(ev[24:17]), .FAN_ERROR_EVENT(ev[16:13]),
        .ANALOG_HIGH_ERROR_EVENT(ev[12:10]), .ZONE_TEMP_ERROR_EVENT(ev[9:8]),
        .ZONE_DIODE_FAULT_EVENT(ev[7:6]), .REGULATOR_HOT_EVENT(ev[5:4]),
        .TERMINATION_EVENT(ev[3:2]), .CORE_VOLTAGE_LIMIT_EVENT(ev[1:0]),
        .GENERAL_INPUT_PIN(pins), .INPUT_ERROR_STATUS(o[32:25]), .INPUT_ERROR_EXT_STATUS(o[24:17]),
        .FAN_ERROR(o[16:13]), .ANALOG_HIGH_ERROR(o[12:10]), .ZONE_TEMP_ERROR(o[9:8]),
        .ZONE_DIODE_FAULT(o[7:6]), .REGULATOR_HOT_ERROR(o[5:4]), .TERMINATION_ERROR(o[3:2]),
        .CORE_VOLTAGE_ERROR(o[1:0]), .INPUT_STATE(in_state), .IRQ(irq)
    );
    always #4 clk = ~clk;
    // Writable bits of each register
    function automatic logic [7:0] wm(logic [7:0] x);
        case (x)
            8'hE4: return 8'h03;
            8'hE6, 8'hE8, 8'hE9, 8'hEB: return 8'h0F;
            8'hED: return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction
    // Suppressed sources for the current state and masks
    function automatic logic [32:0] msk();
        logic [1:0] s;
        logic [7:0] im;
        logic [3:0] f;
        logic [3:0] t;
        s = sh[8'hE4][1:0];
        im = s == 2'h1 ? sh[8'hE5] : s == 2'h2 ? sh[8'hE7] : s == 2'h3 ? sh[8'hEA] : 8'h00;
        im = im | sh[8'hEC];
        f = s == 2'h1 ? sh[8'hE6][3:0] : s == 2'h2 ? sh[8'hE8][3:0] : 4'h0;
        t = s == 2'h2 ? sh[8'hE9][3:0] : s == 2'h3 ? sh[8'hEB][3:0] : 4'h0;
        if (glob)
            return '1;
        return {im, im, f, t[2:0], {4{t[3]}}, sh[8'hED][1:0], sh[8'hED][3:2], sh[8'hED][5:4]};
    endfunction
    function automatic logic [7:0] grp(logic [32:0] v);
        return {1'b0, |v[1:0], |v[3:2], |v[5:4], |v[9:6], |v[12:10], |v[16:13], |v[32:17]};
    endfunction
    task automatic cmp(string n, logic [32:0] e, logic [32:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One clock cycle carrying both a bus access and an event, with expectations noted
    task automatic step(logic w, logic rr, logic [7:0] x, logic [7:0] d, logic c, logic [32:0] v);
        wr <= w;
        rd <= rr;
        addr <= x;
        wdata <= d;
        ev_vld <= c;
        ev <= c ? v : '0;
        if (c) begin
            q_ev.push_back(v & ~msk());
            st = st | grp(v & ~msk());
        end
        if (rr)
            q_rd.push_back(x == 8'hF2 ? st : x == 8'hF3 ? imk : x == 8'hF0 ? {5'h00, glob, 2'h0} :
                sh.exists(x) ? sh[x] : 8'h00);
        if (w && sh.exists(x))
            sh[x] = d & wm(x);
        if (w && x == 8'hF0)
            glob = d[2];
        if (w && x == 8'hF2)
            st = st & ~d;
        if (w && x == 8'hF3)
            imk = d;
        @(posedge clk);
    endtask
    task automatic idle();
        step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0, '0);
    endtask
    task automatic rdr(logic [7:0] x);
        step(1'b0, 1'b1, x, 8'h00, 1'b0, '0);
    endtask
    task automatic wrr(logic [7:0] x, logic [7:0] d);
        step(1'b1, 1'b0, x, d, 1'b0, '0);
    endtask
    task automatic evt(logic [32:0] v);
        step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1, v);
    endtask
    task automatic do_reset();
        srst <= 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        for (a = 8'hE4; a != 8'hEE; a++)
            sh[a] = (a == 8'hE9 || a == 8'hEB) ? 8'h07 : wm(a);
        glob = 1'b0;
        st = 8'h00;
        imk = 8'h00;
        repeat (20) evt({$urandom, 1'($urandom)});
    endtask
    task automatic chk_regs();
        for (a = 8'hE4; a != 8'hEE; a++)
            rdr(a);
        rdr(8'h10);
        rdr(8'hF0);
        rdr(8'hF3);
        rdr(8'hF2);
        idle();
    endtask
    // Result watcher
    always @(posedge clk) begin
        rd_due <= rd;
        ev_due <= ev_vld;
    end
    always @(negedge clk) begin
        if (rd_due)
            cmp("rdata", q_rd.pop_front(), rdata);
        if (ev_due)
            cmp("events", q_ev.pop_front(), o);
    end
    task automatic finish_test();
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        void'($urandom(57));
        do_reset();
        chk_regs();
        for (a = 8'hE4; a != 8'hEE; a++)
            wrr(a, 8'hFF);
        chk_regs();
        for (int i = 0; i < 1500; i++) begin
            r = $urandom % 8;
            a = 8'hE4 + 8'($urandom % 10);
            if (r == 0)
                wrr(a, 8'($urandom));
            else if (r == 1)
                wrr(8'hE4, 8'($urandom));
            else if (r == 2)
                wrr(8'hF0, ($urandom % 6 == 0) ? 8'h04 : 8'h00);
            else if (r == 3)
                rdr(a);
            else
                evt({$urandom, 1'($urandom)});
        end
        pins <= 8'($urandom);
        repeat (6) idle();
        @(negedge clk);
        cmp("input_state", pins, in_state);
        @(posedge clk);
        rdr(8'hF2);
        wrr(8'hF3, 8'h7F);
        idle();
        @(negedge clk);
        cmp("irq", |st, irq);
        @(posedge clk);
        wrr(8'hF2, 8'hFF);
        idle();
        @(negedge clk);
        cmp("irq", 1'b0, irq);
        @(posedge clk);
        rdr(8'hF2);
        idle();
        do_reset();
        chk_regs();
        @(negedge clk);
        cmp("pending", 33'h0, 33'(q_rd.size() + q_ev.size()));
        finish_test();
    end
endmodule
`default_nettype wire

// [rtl/sleep_mask_regs.vh]
// Register offsets, reset values and field positions of the sleep-state error masking block
`ifndef SLEEP_MASK_REGS_VH
`define SLEEP_MASK_REGS_VH

`define ADDR_SLEEP_CONTROL 8'hE4
`define ADDR_LIGHT_SLEEP_INPUT_MASK 8'hE5
`define ADDR_LIGHT_SLEEP_FAN_MASK 8'hE6
`define ADDR_SUSPEND_INPUT_MASK 8'hE7
`define ADDR_SUSPEND_FAN_MASK 8'hE8
`define ADDR_SUSPEND_TEMP_VOLTAGE_MASK 8'hE9
`define ADDR_OFF_STATE_INPUT_MASK 8'hEA
`define ADDR_OFF_STATE_TEMP_VOLTAGE_MASK 8'hEB
`define ADDR_INPUT_ERROR_MASK 8'hEC
`define ADDR_MISC_ERROR_MASK 8'hED
`define ADDR_GLOBAL_CONTROL 8'hF0
`define ADDR_INPUT_STATE 8'hF1
`define ADDR_IRQ_STATUS 8'hF2
`define ADDR_IRQ_MASK 8'hF3

`define RST_SLEEP_CONTROL 2'h3
`define RST_INPUT_MASK 8'hFF
`define RST_FAN_MASK 4'hF
`define RST_TEMP_VOLTAGE_MASK 4'h7
`define RST_MISC_ERROR_MASK 6'h3F
`define RST_GLOBAL_CONTROL 1'h0
`define RST_IRQ_MASK 8'h00

`define SLEEP_S0 2'h0
`define SLEEP_S1 2'h1
`define SLEEP_S3 2'h2
`define SLEEP_S45 2'h3

`define BIT_GLOBAL_MASK 2
`define BIT_ZONE_TEMP 3

`define IRQ_INPUT 0
`define IRQ_FAN 1
`define IRQ_ANALOG 2
`define IRQ_ZONE 3
`define IRQ_REGULATOR 4
`define IRQ_TERMINATION 5
`define IRQ_CORE_VOLTAGE 6

`endif

// [rtl/sleep_state_error_masking.v]
// Sleep-state and per-source error masking with register port and interrupt
//
// Contract
// - In S1, fan inputs one to four masked by light-sleep fan mask bits, reset 0Fh.
// - In S3, general inputs zero to seven masked by suspend input mask, reset FFh.
// - In S3, fan inputs one to four masked by suspend fan mask, reset 0Fh.
// - In S3, analog twelve to fourteen masked by suspend mask bits 0-2, reset 07h.
// - In S3, suspend mask bit 3 masks zone one and two temperature and diode errors.
// - In S4/5, general inputs masked by off-state input mask, reset FFh.
// - In S4/5, analog twelve to fourteen masked by off-state bits 0-2, reset 07h.
// - In S4/5, off-state bit 3 masks zone temperature and diode fault errors.
// - Input error mask masks general inputs in every state, reset FFh.
// - Input error mask gates both basic and extended input error status bits.
// - Live input state register always shows real input levels, unmasked.
// - Misc mask bits 0 and 1 mask regulator-hot inputs; register resets 3Fh.
// - Misc mask bits 2 and 3 mask termination inputs one and two.
// - Misc mask bits 4 and 5 mask core-voltage limit errors of analog seven, eight.
// - Sleep field: 00 S0 none, 01 S1, 10 S3, 11 S4/5 masking.
// - Global mask suppresses every error event, leaving other registers unchanged.
// - In S1, general inputs masked by light-sleep input mask, reset FFh.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "sleep_mask_regs.vh"

module sleep_state_error_masking #(
    parameter INPUTS = 8,
    parameter FANS = 4
) (
    // Clock and reset
    input wire CORE_CLK,
    input wire SRST,
    // Register port
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output reg [7:0] REG_RDATA,
    // Raw error events
    input wire [INPUTS-1:0] INPUT_ERROR_EVENT,
    input wire [INPUTS-1:0] INPUT_ERROR_EXT_EVENT,
    input wire [FANS-1:0] FAN_ERROR_EVENT,
    input wire [2:0] ANALOG_HIGH_ERROR_EVENT,
    input wire [1:0] ZONE_TEMP_ERROR_EVENT,
    input wire [1:0] ZONE_DIODE_FAULT_EVENT,
    input wire [1:0] REGULATOR_HOT_EVENT,
    input wire [1:0] TERMINATION_EVENT,
    input wire [1:0] CORE_VOLTAGE_LIMIT_EVENT,
    // Live general-purpose input pins
    input wire [INPUTS-1:0] GENERAL_INPUT_PIN,
    // Masked error events
    output reg [INPUTS-1:0] INPUT_ERROR_STATUS,
    output reg [INPUTS-1:0] INPUT_ERROR_EXT_STATUS,
    output reg [FANS-1:0] FAN_ERROR,
    output reg [2:0] ANALOG_HIGH_ERROR,
    output reg [1:0] ZONE_TEMP_ERROR,
    output reg [1:0] ZONE_DIODE_FAULT,
    output reg [1:0] REGULATOR_HOT_ERROR,
    output reg [1:0] TERMINATION_ERROR,
    output reg [1:0] CORE_VOLTAGE_ERROR,
    // Live input state and interrupt
    output reg [INPUTS-1:0] INPUT_STATE,
    output wire IRQ
);

    reg [1:0] sleep_state_field;
    reg [INPUTS-1:0] light_sleep_input_mask;
    reg [FANS-1:0] light_sleep_fan_mask;
    reg [INPUTS-1:0] suspend_input_mask;
    reg [FANS-1:0] suspend_fan_mask;
    reg [3:0] suspend_temp_voltage_mask;
    reg [INPUTS-1:0] off_state_input_mask;
    reg [3:0] off_state_temp_voltage_mask;
    reg [INPUTS-1:0] input_error_mask;
    reg [5:0] misc_error_mask;
    reg global_error_mask;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;
    reg [INPUTS-1:0] pin_s1;
    reg [INPUTS-1:0] pin_s2;
    reg [INPUTS-1:0] pin_s3;

    reg [INPUTS-1:0] input_kill;
    reg [FANS-1:0] fan_kill;
    reg [2:0] analog_kill;
    reg zone_kill;
    reg [1:0] regulator_kill;
    reg [1:0] termination_kill;
    reg [1:0] core_kill;
    reg [INPUTS-1:0] next_input_err;
    reg [INPUTS-1:0] next_input_ext;
    reg [FANS-1:0] next_fan;
    reg [2:0] next_analog;
    reg [1:0] next_zone_temp;
    reg [1:0] next_zone_diode;
    reg [1:0] next_regulator;
    reg [1:0] next_termination;
    reg [1:0] next_core;
    reg [7:0] events;
    reg [7:0] next_rdata;

    // Sleep mask applies only when the field selects the matching state
    function in_state;
        input [1:0] field;
        input [1:0] state;
        begin
            in_state = (field == state);
        end
    endfunction

    // Mask selection per source
    always @* begin
        input_kill = {INPUTS{global_error_mask}} | input_error_mask;
        fan_kill = {FANS{global_error_mask}};
        analog_kill = {3{global_error_mask}};
        zone_kill = global_error_mask;
        if (in_state(sleep_state_field, `SLEEP_S1)) begin
            input_kill = input_kill | light_sleep_input_mask;
            fan_kill = fan_kill | light_sleep_fan_mask;
        end
        if (in_state(sleep_state_field, `SLEEP_S3)) begin
            input_kill = input_kill | suspend_input_mask;
            fan_kill = fan_kill | suspend_fan_mask;
            analog_kill = analog_kill | suspend_temp_voltage_mask[2:0];
            zone_kill = zone_kill | suspend_temp_voltage_mask[`BIT_ZONE_TEMP];
        end
        if (in_state(sleep_state_field, `SLEEP_S45)) begin
            input_kill = input_kill | off_state_input_mask;
            analog_kill = analog_kill | off_state_temp_voltage_mask[2:0];
            zone_kill = zone_kill | off_state_temp_voltage_mask[`BIT_ZONE_TEMP];
        end
        regulator_kill = {2{global_error_mask}} | misc_error_mask[1:0];
        termination_kill = {2{global_error_mask}} | misc_error_mask[3:2];
        core_kill = {2{global_error_mask}} | misc_error_mask[5:4];
    end

    // Masked events
    always @* begin
        next_input_err = INPUT_ERROR_EVENT & ~input_kill;
        next_input_ext = INPUT_ERROR_EXT_EVENT & ~input_kill;
        next_fan = FAN_ERROR_EVENT & ~fan_kill;
        next_analog = ANALOG_HIGH_ERROR_EVENT & ~analog_kill;
        next_zone_temp = ZONE_TEMP_ERROR_EVENT & ~{2{zone_kill}};
        next_zone_diode = ZONE_DIODE_FAULT_EVENT & ~{2{zone_kill}};
        next_regulator = REGULATOR_HOT_EVENT & ~regulator_kill;
        next_termination = TERMINATION_EVENT & ~termination_kill;
        next_core = CORE_VOLTAGE_LIMIT_EVENT & ~core_kill;
        events = 8'h00;
        events[`IRQ_INPUT] = |(next_input_err | next_input_ext);
        events[`IRQ_FAN] = |next_fan;
        events[`IRQ_ANALOG] = |next_analog;
        events[`IRQ_ZONE] = |(next_zone_temp | next_zone_diode);
        events[`IRQ_REGULATOR] = |next_regulator;
        events[`IRQ_TERMINATION] = |next_termination;
        events[`IRQ_CORE_VOLTAGE] = |next_core;
    end

    // Read mux, reserved bits zero
    always @* begin
        next_rdata = 8'h00;
        case (REG_ADDR)
            `ADDR_SLEEP_CONTROL: next_rdata = {6'h00, sleep_state_field};
            `ADDR_LIGHT_SLEEP_INPUT_MASK: next_rdata = light_sleep_input_mask;
            `ADDR_LIGHT_SLEEP_FAN_MASK: next_rdata = {4'h0, light_sleep_fan_mask};
            `ADDR_SUSPEND_INPUT_MASK: next_rdata = suspend_input_mask;
            `ADDR_SUSPEND_FAN_MASK: next_rdata = {4'h0, suspend_fan_mask};
            `ADDR_SUSPEND_TEMP_VOLTAGE_MASK: next_rdata = {4'h0, suspend_temp_voltage_mask};
            `ADDR_OFF_STATE_INPUT_MASK: next_rdata = off_state_input_mask;
            `ADDR_OFF_STATE_TEMP_VOLTAGE_MASK: next_rdata = {4'h0, off_state_temp_voltage_mask};
            `ADDR_INPUT_ERROR_MASK: next_rdata = input_error_mask;
            `ADDR_MISC_ERROR_MASK: next_rdata = {2'h0, misc_error_mask};
            `ADDR_GLOBAL_CONTROL: next_rdata = {5'h00, global_error_mask, 2'h0};
            `ADDR_INPUT_STATE: next_rdata = INPUT_STATE;
            `ADDR_IRQ_STATUS: next_rdata = irq_status;
            `ADDR_IRQ_MASK: next_rdata = irq_mask;
            default: next_rdata = 8'h00;
        endcase
    end

    // Register write decode, shared by every writable register
    function write_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            write_hit = strobe && (addr == target);
        end
    endfunction

    // Sleep-state field
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            sleep_state_field <= `RST_SLEEP_CONTROL;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_SLEEP_CONTROL)) begin
            sleep_state_field <= REG_WDATA[1:0];
        end
    end

    // Light-sleep input mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            light_sleep_input_mask <= `RST_INPUT_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_LIGHT_SLEEP_INPUT_MASK)) begin
            light_sleep_input_mask <= REG_WDATA;
        end
    end

    // Light-sleep fan mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            light_sleep_fan_mask <= `RST_FAN_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_LIGHT_SLEEP_FAN_MASK)) begin
            light_sleep_fan_mask <= REG_WDATA[3:0];
        end
    end

    // Suspend input mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            suspend_input_mask <= `RST_INPUT_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_SUSPEND_INPUT_MASK)) begin
            suspend_input_mask <= REG_WDATA;
        end
    end

    // Suspend fan mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            suspend_fan_mask <= `RST_FAN_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_SUSPEND_FAN_MASK)) begin
            suspend_fan_mask <= REG_WDATA[3:0];
        end
    end

    // Suspend temperature and voltage mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            suspend_temp_voltage_mask <= `RST_TEMP_VOLTAGE_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_SUSPEND_TEMP_VOLTAGE_MASK)) begin
            suspend_temp_voltage_mask <= REG_WDATA[3:0];
        end
    end

    // Off-state input mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            off_state_input_mask <= `RST_INPUT_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_OFF_STATE_INPUT_MASK)) begin
            off_state_input_mask <= REG_WDATA;
        end
    end

    // Off-state temperature and voltage mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            off_state_temp_voltage_mask <= `RST_TEMP_VOLTAGE_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_OFF_STATE_TEMP_VOLTAGE_MASK)) begin
            off_state_temp_voltage_mask <= REG_WDATA[3:0];
        end
    end

    // Always-on input error mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            input_error_mask <= `RST_INPUT_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_INPUT_ERROR_MASK)) begin
            input_error_mask <= REG_WDATA;
        end
    end

    // Miscellaneous error mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            misc_error_mask <= `RST_MISC_ERROR_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_MISC_ERROR_MASK)) begin
            misc_error_mask <= REG_WDATA[5:0];
        end
    end

    // Global mask bit
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            global_error_mask <= `RST_GLOBAL_CONTROL;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_GLOBAL_CONTROL)) begin
            global_error_mask <= REG_WDATA[`BIT_GLOBAL_MASK];
        end
    end

    // Interrupt mask
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_mask <= `RST_IRQ_MASK;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_IRQ_MASK)) begin
            irq_mask <= REG_WDATA;
        end
    end

    // Interrupt status, set wins over write-one-to-clear
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_status <= 8'h00;
        end else if (write_hit(REG_WR, REG_ADDR, `ADDR_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~REG_WDATA) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Read data stands for one cycle after the read strobe
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= REG_RD ? next_rdata : 8'h00;
        end
    end

    // Pin synchroniser
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            pin_s1 <= {INPUTS{1'b0}};
            pin_s2 <= {INPUTS{1'b0}};
            pin_s3 <= {INPUTS{1'b0}};
        end else begin
            pin_s1 <= GENERAL_INPUT_PIN;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Live input state, change accepted when stages two and three agree
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            INPUT_STATE <= {INPUTS{1'b0}};
        end else begin
            INPUT_STATE <= (pin_s2 & pin_s3) | (INPUT_STATE & (pin_s2 | pin_s3));
        end
    end

    // Input error status, basic and extended
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            INPUT_ERROR_STATUS <= {INPUTS{1'b0}};
            INPUT_ERROR_EXT_STATUS <= {INPUTS{1'b0}};
        end else begin
            INPUT_ERROR_STATUS <= next_input_err;
            INPUT_ERROR_EXT_STATUS <= next_input_ext;
        end
    end

    // Other masked event outputs, one cycle after the event
    always @(posedge CORE_CLK) begin
        if (SRST) begin
            FAN_ERROR <= {FANS{1'b0}};
            ANALOG_HIGH_ERROR <= 3'h0;
            ZONE_TEMP_ERROR <= 2'h0;
            ZONE_DIODE_FAULT <= 2'h0;
            REGULATOR_HOT_ERROR <= 2'h0;
            TERMINATION_ERROR <= 2'h0;
            CORE_VOLTAGE_ERROR <= 2'h0;
        end else begin
            FAN_ERROR <= next_fan;
            ANALOG_HIGH_ERROR <= next_analog;
            ZONE_TEMP_ERROR <= next_zone_temp;
            ZONE_DIODE_FAULT <= next_zone_diode;
            REGULATOR_HOT_ERROR <= next_regulator;
            TERMINATION_ERROR <= next_termination;
            CORE_VOLTAGE_ERROR <= next_core;
        end
    end

    assign IRQ = |(irq_status & irq_mask);

endmodule

`default_nettype wire
